// ===== cms_consts.vh
// How it works
// RQ1 - The subtract form writes ra times rb and ra2 minus rb2 to rd or to their feedback registers in one step.
// RQ2 - The two-minus form writes ra times rb and the constant two minus ra2 in the same step.
// RQ3 - The ALU-negate flag negates the ALU result, only for non-integer operand types.
// RQ4 - The multiplier-negate flag negates the product, only for non-integer operand types.
// RQ5 - The write-output flag also drives the result onto the local bus with the write-enable strobe.
// RQ6 - The latch-output flag drives the result onto the local bus with the address-latch strobe instead.
// RQ7 - The issuer names ra2 only when ra or ra2 is a feedback register.
// RQ8 - The issuer names rb2 only when rb or rb2 is a feedback register.
// RQ9 - The issuer never feeds a feedback register to a double-precision multiply.
// RQ10 - The multiplier rb operand comes from B entries 0 to 9, the aux register, product feedback, immediate or one.
// RQ11 - The word decodes as 31:30 zero, 29 write-output, 28 latch-output, 27:24 ra, 23:20 rb, 19:15 rd, 14:11 op.
// RQ12 - The output-source bit picks whether the ALU result or the product goes to rd and the bus.
`ifndef CMS_CONSTS_VH
`define CMS_CONSTS_VH
// ********************************
// Register byte addresses
// ********************************
`define CMS_ADDR_INSTR   8'h00
`define CMS_ADDR_IMM     8'h04
`define CMS_ADDR_RESULT  8'h08
`define CMS_ADDR_STATUS  8'h0c
`define CMS_ADDR_AUX     8'h10
`define CMS_ADDR_ALU_FEEDBACK_REG   8'h14
`define CMS_ADDR_PRODFB  8'h18
`define CMS_BASE_AFILE   2'h1
`define CMS_BASE_BFILE   2'h2
// ********************************
// Instruction fields
// ********************************
`define CMS_F_TOP        31:30
`define CMS_F_WROUT      29
`define CMS_F_LATCH      28
`define CMS_F_RA         27:24
`define CMS_F_RB         23:20
`define CMS_F_RD         19:15
`define CMS_F_OPSEL      14:11
`define CMS_F_INT        9
`define CMS_F_PA         8
`define CMS_F_PB         7
`define CMS_F_OSRC       6
`define CMS_F_NEGA       3
`define CMS_F_NEGM       2
`define CMS_F_VAR        1:0
// ********************************
// Codes and constants
// ********************************
`define CMS_VAR_SUB      2'h1
`define CMS_VAR_TWO      2'h2
`define CMS_VAR_RSUB     2'h3
`define CMS_SRC_LAST     4'h9
`define CMS_SRC_AUX      4'h0a
`define CMS_SRC_FB       4'h0b
`define CMS_SRC_IMM      4'h0c
`define CMS_SRC_ONE      4'h0d
`define CMS_RD_BFIRST    5'h0a
`define CMS_RD_BLAST     5'h13
`define CMS_RD_AUX       5'h14
`define CMS_RD_AFILE_MAX 5'h09
`define CMS_FILE_DEPTH   10
`define CMS_CONST_TWO    32'h00000002
`define CMS_CONST_ONE    32'h00000001
`define CMS_SIGN_BIT     32'h80000000
`define CMS_RESET_WORD   32'h00000000
`endif

// ===== cms_datapath.v
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "cms_consts.vh"
module cms_datapath
(
   // Clock and reset
   input  wire        clk_i,
   input  wire        reset_n_i,
   // Avalon-MM slave
   input  wire [7:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   output reg  [31:0] avs_readdata_o,
   output wire        avs_waitrequest_o,
   // Local address/data bus
   output reg  [31:0] local_addr_data_bus_o,
   output reg         lad_write_strobe_o,
   output reg         addr_latch_strobe_o
);
   // ********************************
   // Storage
   // ********************************
   reg [31:0] afile [0:`CMS_FILE_DEPTH-1];
   reg [31:0] bfile [0:`CMS_FILE_DEPTH-1];
   reg [31:0] aux_const_reg;
   reg [31:0] alu_feedback_reg;
   reg [31:0] product_feedback_reg;
   reg [31:0] imm_data;
   reg [31:0] last_result;
   reg        bad_word;
   reg        ack;

   // ********************************
   // Bus handshake
   // ********************************
   // One wait cycle on every access; writes land on the edge that ends the cycle after it
   // A request still held after its accepted edge starts a fresh access
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
   wire wr_go  = avs_write_i & ack;
   wire rd_pre = avs_read_i & ~ack;
   wire [1:0] reg_base = avs_address_i[7:6];
   wire [3:0] reg_idx  = avs_address_i[5:2];
   wire idx_ok = (reg_idx <= `CMS_SRC_LAST);
   wire wr_afile = wr_go & (reg_base == `CMS_BASE_AFILE) & idx_ok;
   wire wr_bfile = wr_go & (reg_base == `CMS_BASE_BFILE) & idx_ok;
   wire issue = wr_go & (avs_address_i == `CMS_ADDR_INSTR);
   // Scalar write enables; the result and status words are read-only
   reg        wr_imm;
   reg        wr_aux;
   reg        wr_alu_feedback_reg;
   reg        wr_prodfb;
   always @*
   begin
      wr_imm    = 1'b0;
      wr_aux    = 1'b0;
      wr_alu_feedback_reg  = 1'b0;
      wr_prodfb = 1'b0;
      if (wr_go)
      begin
         case (avs_address_i)
            `CMS_ADDR_IMM:    wr_imm    = 1'b1;
            `CMS_ADDR_AUX:    wr_aux    = 1'b1;
            `CMS_ADDR_ALU_FEEDBACK_REG:  wr_alu_feedback_reg  = 1'b1;
            `CMS_ADDR_PRODFB: wr_prodfb = 1'b1;
            default:          wr_imm    = 1'b0;
         endcase
      end
   end

   // ********************************
   // Instruction decode
   // ********************************
   wire [31:0] iw = avs_writedata_i;
   // Word layout
   wire       top_ok  = (iw[`CMS_F_TOP] == 2'h0);
   wire       f_wrout = iw[`CMS_F_WROUT];
   wire       f_latch = iw[`CMS_F_LATCH];
   wire [3:0] f_ra    = iw[`CMS_F_RA];
   wire [3:0] f_rb    = iw[`CMS_F_RB];
   wire [4:0] f_rd    = iw[`CMS_F_RD];
   wire [1:0] f_var   = iw[`CMS_F_VAR];
   wire       f_int   = iw[`CMS_F_INT];
   wire       f_pa    = iw[`CMS_F_PA];
   wire       f_pb    = iw[`CMS_F_PB];
   wire       f_osrc  = iw[`CMS_F_OSRC];
   wire       f_nega  = iw[`CMS_F_NEGA];
   wire       f_negm  = iw[`CMS_F_NEGM];
   wire       var_ok  = (f_var != 2'h0);
   // RQ11 only well-formed words run
   wire       exec    = issue & top_ok & var_ok;
   wire       two_form = (f_var == `CMS_VAR_TWO);
   wire       neg_alu  = f_nega & ~f_int;
   wire       neg_prod = f_negm & ~f_int;

   // ********************************
   // Operand selection
   // ********************************
   // Codes above one and unused file slots read as zero
   reg [31:0] fld_a;
   reg [31:0] fld_b;
   always @*
   begin
      case (f_ra)
         `CMS_SRC_AUX: fld_a = aux_const_reg;
         `CMS_SRC_FB:  fld_a = alu_feedback_reg;
         `CMS_SRC_IMM: fld_a = imm_data;
         `CMS_SRC_ONE: fld_a = `CMS_CONST_ONE;
         default:      fld_a = (f_ra <= `CMS_SRC_LAST) ? afile[f_ra] : `CMS_RESET_WORD;
      endcase
   end
   // RQ10 rb source choice
   always @*
   begin
      case (f_rb)
         `CMS_SRC_AUX: fld_b = aux_const_reg;
         `CMS_SRC_FB:  fld_b = product_feedback_reg;
         `CMS_SRC_IMM: fld_b = imm_data;
         `CMS_SRC_ONE: fld_b = `CMS_CONST_ONE;
         default:      fld_b = (f_rb <= `CMS_SRC_LAST) ? bfile[f_rb] : `CMS_RESET_WORD;
      endcase
   end
   // The shared field feeds one side of each pair, the other side is a
   // feedback register, except that the two-minus form with f_pb clear takes rb and rb2 both from the field.
   // RQ7 ra pair feedback
   wire [31:0] op_ra  = f_pa ? fld_a : alu_feedback_reg;
   wire [31:0] op_ra2 = f_pa ? product_feedback_reg : fld_a;
   // RQ8 rb pair feedback
   wire [31:0] op_rb  = (f_pb | two_form) ? fld_b : product_feedback_reg;
   wire [31:0] op_rb2 = f_pb ? alu_feedback_reg : fld_b;

   // ********************************
   // Arithmetic
   // ********************************
   // Integer arithmetic only; for real types negation flips the sign bit.
   // RQ9 is the issuer's to keep: feedback operands are not screened here.
   wire [63:0] full_prod = op_ra * op_rb;
   wire [31:0] prod_raw  = full_prod[31:0];
   reg  [31:0] alu_raw;
   always @*
   begin
      case (f_var)
         // RQ1 ra2 minus rb2
         `CMS_VAR_SUB:  alu_raw = op_ra2 - op_rb2;
         // RQ2 two minus ra2
         `CMS_VAR_TWO:  alu_raw = `CMS_CONST_TWO - op_ra2;
         `CMS_VAR_RSUB: alu_raw = op_rb2 - op_ra2;
         default:       alu_raw = `CMS_RESET_WORD;
      endcase
   end
   // RQ3 ALU negate
   wire [31:0] alu_res  = neg_alu ? (alu_raw ^ `CMS_SIGN_BIT) : alu_raw;
   // RQ4 product negate
   wire [31:0] prod_res = neg_prod ? (prod_raw ^ `CMS_SIGN_BIT) : prod_raw;
   // RQ12 output source pick
   wire [31:0] out_res  = f_osrc ? prod_res : alu_res;

   // ********************************
   // Register files
   // ********************************
   // Register writes and instructions share one bus, so an entry never
   // sees a bus write and a result in the same cycle
   wire       rd_in_a   = (f_rd <= `CMS_RD_AFILE_MAX);
   wire       rd_in_b   = (f_rd >= `CMS_RD_BFIRST) & (f_rd <= `CMS_RD_BLAST);
   wire       rd_to_aux = (f_rd == `CMS_RD_AUX);
   wire [4:0] b_slot    = f_rd - `CMS_RD_BFIRST;
   wire [9:0] a_bus_sel = wr_afile ? (10'h001 << reg_idx) : 10'h000;
   wire [9:0] b_bus_sel = wr_bfile ? (10'h001 << reg_idx) : 10'h000;
   wire [9:0] a_res_sel = (exec & rd_in_a) ? (10'h001 << f_rd[3:0]) : 10'h000;
   wire [9:0] b_res_sel = (exec & rd_in_b) ? (10'h001 << b_slot[3:0]) : 10'h000;
   genvar     k;
   generate
      for (k = 0; k < `CMS_FILE_DEPTH; k = k + 1)
      begin : g_entry
         always @(posedge clk_i)
         begin
            if (!reset_n_i)
            begin
               afile[k] <= `CMS_RESET_WORD;
               bfile[k] <= `CMS_RESET_WORD;
            end
            else
            begin
               // RQ1 bus word or result
               if (a_bus_sel[k])
                  afile[k] <= avs_writedata_i;
               else if (a_res_sel[k])
                  afile[k] <= out_res;
               if (b_bus_sel[k])
                  bfile[k] <= avs_writedata_i;
               else if (b_res_sel[k])
                  bfile[k] <= out_res;
            end
         end
      end
   endgenerate

   // ********************************
   // Register updates
   // ********************************
   always @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         aux_const_reg        <= `CMS_RESET_WORD;
         alu_feedback_reg     <= `CMS_RESET_WORD;
         product_feedback_reg <= `CMS_RESET_WORD;
         imm_data             <= `CMS_RESET_WORD;
         last_result          <= `CMS_RESET_WORD;
         bad_word             <= 1'b0;
      end
      else
      begin
         if (wr_imm)
            imm_data <= avs_writedata_i;
         if (wr_aux)
            aux_const_reg <= avs_writedata_i;
         else if (exec & rd_to_aux)
            aux_const_reg <= out_res;
         // RQ1 unselected result refreshes its own feedback register
         if (wr_alu_feedback_reg)
            alu_feedback_reg <= avs_writedata_i;
         else if (exec & f_osrc)
            alu_feedback_reg <= alu_res;
         if (wr_prodfb)
            product_feedback_reg <= avs_writedata_i;
         else if (exec & ~f_osrc)
            product_feedback_reg <= prod_res;
         // Malformed words are dropped and flagged until the next good one
         if (issue)
            bad_word <= ~exec;
         if (exec)
            last_result <= out_res;
      end
   end

   // ********************************
   // Local bus output
   // ********************************
   // Both flags set: only the latch strobe goes out
   wire next_latch_strobe = exec & f_latch;
   wire next_write_strobe = exec & f_wrout & ~f_latch;
   wire bus_load          = exec & (f_wrout | f_latch);
   always @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         local_addr_data_bus_o <= `CMS_RESET_WORD;
         lad_write_strobe_o    <= 1'b0;
         addr_latch_strobe_o   <= 1'b0;
      end
      else
      begin
         // RQ6 latch strobe wins
         addr_latch_strobe_o <= next_latch_strobe;
         // RQ5 write strobe
         lad_write_strobe_o  <= next_write_strobe;
         if (bus_load)
            local_addr_data_bus_o <= out_res;
      end
   end

   // ********************************
   // Read path and ack
   // ********************************
   // Unmapped addresses read as zero
   reg [31:0] rd_word;
   always @*
   begin
      rd_word = `CMS_RESET_WORD;
      if ((reg_base == `CMS_BASE_AFILE) & idx_ok)
         rd_word = afile[reg_idx];
      else if ((reg_base == `CMS_BASE_BFILE) & idx_ok)
         rd_word = bfile[reg_idx];
      else
      begin
         case (avs_address_i)
            `CMS_ADDR_IMM:    rd_word = imm_data;
            `CMS_ADDR_RESULT: rd_word = last_result;
            `CMS_ADDR_STATUS: rd_word = {31'h0, bad_word};
            `CMS_ADDR_AUX:    rd_word = aux_const_reg;
            `CMS_ADDR_ALU_FEEDBACK_REG:  rd_word = alu_feedback_reg;
            `CMS_ADDR_PRODFB: rd_word = product_feedback_reg;
            default:          rd_word = `CMS_RESET_WORD;
         endcase
      end
   end
   // Read data is taken in the wait cycle, so it stands when the wait drops
   always @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         ack            <= 1'b0;
         avs_readdata_o <= `CMS_RESET_WORD;
      end
      else
      begin
         ack <= (avs_read_i | avs_write_i) & ~ack;
         if (rd_pre)
            avs_readdata_o <= rd_word;
      end
   end
endmodule // cms_datapath
`default_nettype wire

// ===== cms_checker.sv
`timescale 1ns/1ns
`default_nettype none
module cms_checker
(
   // Datapath ports
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   input wire logic [7:0]  avs_address_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic        avs_waitrequest_o,
   input wire logic [31:0] local_addr_data_bus_o,
   input wire logic        lad_write_strobe_o,
   input wire logic        addr_latch_strobe_o
);
   wire logic take = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h00
      && avs_writedata_i[31:30] == 2'h0 && avs_writedata_i[1:0] != 2'h0;
   wire logic e_go = take && avs_writedata_i[29] && !avs_writedata_i[28];
   wire logic h_go = take && avs_writedata_i[28];
   wire logic ws = lad_write_strobe_o;
   wire logic ls = addr_latch_strobe_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   property p_wait; avs_write_i && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
   a_wait: assert property (p_wait) else $error("long wait");
   property p_we_go; e_go |=> ws && !ls; endproperty
   a_we_go: assert property (p_we_go) else $error("no write strobe");
   property p_lt_go; h_go |=> ls && !ws; endproperty
   a_lt_go: assert property (p_lt_go) else $error("no latch strobe");
   property p_we_src; ws |-> $past(e_go); endproperty
   a_we_src: assert property (p_we_src) else $error("stray write strobe");
   property p_lt_src; ls |-> $past(h_go); endproperty
   a_lt_src: assert property (p_lt_src) else $error("stray latch strobe");
   property p_we_one; ws |=> !ws; endproperty
   a_we_one: assert property (p_we_one) else $error("long write strobe");
   property p_lt_one; ls |=> !ls; endproperty
   a_lt_one: assert property (p_lt_one) else $error("long latch strobe");
   property p_bus; $changed(local_addr_data_bus_o) |-> ws || ls; endproperty
   a_bus: assert property (p_bus) else $error("bus moved silently");
endmodule // cms_checker
bind cms_datapath cms_checker u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
   .local_addr_data_bus_o(local_addr_data_bus_o), .lad_write_strobe_o(lad_write_strobe_o),
   .addr_latch_strobe_o(addr_latch_strobe_o));
`default_nettype wire

// ===== cms_bus_sink.sv
`timescale 1ns/1ns
`default_nettype none
module cms_bus_sink
(
   // Local bus in
   input wire logic        clk_i,
   input wire logic [31:0] bus_i,
   input wire logic        we_i,
   input wire logic        latch_i,
   // Word taken, counts: write in 31:8, latch in 7:0
   output var logic [31:0] data_o,
   output var logic [31:0] cnt_o
);
   initial cnt_o = 32'h0;
   always @(posedge clk_i)
   begin
      if (we_i || latch_i)
         data_o <= bus_i;
      cnt_o <= cnt_o + {23'h0, we_i, 7'h0, latch_i};
   end
endmodule // cms_bus_sink
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk = 1'b0, reset_n = 1'b0, rd = 1'b0, wr = 1'b0, wait_r, we, lt;
   logic [7:0] adr = 8'h0;
   logic [31:0] wd = 32'h0, rdata, bus, s_data, s_cnt, q;
   int error_cnt = 0, n_tests = 0;
   always #10 clk = ~clk;
   cms_datapath DUT (.clk_i(clk), .reset_n_i(reset_n), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
      .local_addr_data_bus_o(bus), .lad_write_strobe_o(we), .addr_latch_strobe_o(lt));
   cms_bus_sink u_sink (.clk_i(clk), .bus_i(bus), .we_i(we), .latch_i(lt), .data_o(s_data), .cnt_o(s_cnt));
   task automatic stop_test(input logic hung);
      error_cnt += hung;
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Request held until waitrequest is sampled low at a rising edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      {adr, wd} <= {a, d};
      {wr, rd} <= {w, !w};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wait_r !== 1'b0 && n < 20);
      q = rdata;
      {wr, rd} <= 2'h0;
      if (wait_r !== 1'b0)
         stop_test(1'b1);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      error_cnt += (g !== e);
      if (g !== e)
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic t_sub;
      acc(1'b1, 8'h4c, 32'h7);
      acc(1'b1, 8'h88, 32'h5);
      acc(1'b1, 8'h18, 32'h3);
      acc(1'b1, 8'h00, 32'h232a03cd);
      rdchk(8'h10, 32'h23);
      rdchk(8'h14, 32'h3);
      chk(s_data, 32'h23);
      chk(s_cnt, 32'h100);
   endtask
   task automatic t_two;
      acc(1'b1, 8'h00, 32'h132a018a);
      rdchk(8'h08, 32'h7fffffff);
      rdchk(8'h18, 32'h23);
      chk(s_data, 32'h7fffffff);
      chk(s_cnt, 32'h101);
   endtask
   task automatic t_rsub;
      acc(1'b1, 8'h00, 32'h33df81c7);
      rdchk(8'h08, 32'h80000007);
      rdchk(8'h14, 32'hffffffe0);
      chk(s_data, 32'h80000007);
      chk(s_cnt, 32'h102);
   endtask
   task automatic t_fb;
      acc(1'b1, 8'h04, 32'hd);
      acc(1'b1, 8'h10, 32'h4);
      acc(1'b1, 8'h14, 32'h6);
      acc(1'b1, 8'h18, 32'h5);
      acc(1'b1, 8'h00, 32'h0ca60201);
      rdchk(8'h88, 32'h9);
      rdchk(8'h18, 32'h1e);
      rdchk(8'h08, 32'h9);
      rdchk(8'h0c, 32'h0);
      chk(s_cnt, 32'h102);
   endtask
   task automatic t_bad;
      acc(1'b1, 8'h00, 32'hc0000001);
      rdchk(8'h0c, 32'h1);
      rdchk(8'h3c, 32'h0);
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      t_sub();
      t_two();
      t_rsub();
      t_bad();
      t_fb();
      stop_test(1'b0);
   end
endmodule // tb_top
`default_nettype wire
